/* File: design/tgc_map.vh */
// constants for the gated 16-bit counter block
// assumes one 40 MHz system clock; no register bus, all control is by ports
`ifndef TGC_MAP_VH
`define TGC_MAP_VH
// gate source select codes
`define TGC_SRC_PIN 2'h0
`define TGC_SRC_T8_OVF 2'h1
`define TGC_SRC_PERIOD 2'h2
`define TGC_SRC_WDOG 2'h3
// reset value and count limits
`define TGC_CNT_RST 16'h0000
`define TGC_CNT_MAX 16'hffff
`define TGC_T8_MAX 8'hff
// interrupt vector for wake from sleep
`define TGC_IRQ_VECTOR 16'h0004
`endif

/* File: design/tgc_gate_counter.v */
// gate control, toggle / single-pulse modes and 16-bit counter with overflow
// assumes count_tick_i is a one-cycle pulse for each rising edge of the
// chosen count clock, already in clk_i domain; gate pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "tgc_map.vh"

// What this block does
// - gating applies only when gate_enable set
// - count on clock edge when gate active
// - polarity picks active gate level
// - two-bit select picks one of four sources
// - eight-bit timer wrap gives rising pulse
// - period timer reset gives rising pulse
// - gate on watchdog source powers watchdog
// - gate use never enables watchdog reset/wake
// - watchdog interval still from option bits
// - toggle mode flips on each rising edge after polarity
// - toggle flop held clear when disabled
// - go bit arms counting from next edge
// - trailing edge clears go, others ignored
// - clearing single-pulse enable clears go
// - toggle plus single-pulse measures one cycle
// - gate level status always valid
// - gate falling edge sets event flag
// - counter wrap sets overflow flag
// - overflow irq needs all four enables
// - sleep overflow wakes, vectors to 0004h if global on
// - counter_on and gate_enable select operation
module tgc_gate_counter #(
  parameter CNT_W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire count_tick_i, // one pulse per count clock rising edge
  input wire counter_on_i,
  input wire gate_enable_i,
  input wire gate_polarity_i,
  input wire [1:0] gate_source_select_i,
  input wire gate_toggle_enable_i,
  input wire gate_single_pulse_enable_i,
  input wire go_set_i, // software writes go/done = 1
  input wire gate_input_pin_i, // asynchronous pin
  input wire [7:0] eight_bit_timer_count_i,
  input wire [7:0] period_timer_count_i,
  input wire watchdog_overflow_i,
  input wire watchdog_fuse_enable_i,
  input wire prescaler_assignment_i,
  input wire [2:0] prescaler_rate_i,
  input wire counter_load_i, // software write of counter pair
  input wire [CNT_W-1:0] counter_load_val_i,
  input wire gate_event_flag_clr_i,
  input wire overflow_flag_clr_i,
  input wire gate_event_irq_enable_i,
  input wire overflow_irq_enable_i,
  input wire peripheral_irq_enable_i,
  input wire global_irq_enable_i,
  input wire sleep_i,
  input wire external_sync_disable_i,
  output reg [CNT_W-1:0] counter_pair_o,
  output reg single_pulse_go_done_o,
  output reg gate_level_status_o,
  output reg gate_event_flag_o,
  output reg overflow_flag_o,
  output reg irq_o,
  output reg wake_o,
  output reg [15:0] wake_vector_o,
  output reg watchdog_osc_on_o,
  output reg watchdog_reset_allow_o,
  output reg [3:0] watchdog_interval_sel_o
);

  // ************************************************
  // input synchronisers
  // ************************************************
  reg [2:0] pin_s_r; // pin: three flops, change once 2nd and 3rd agree
  reg pin_q_r; // filtered pin level
  reg [2:0] wdt_s_r; // watchdog overflow, asynchronous oscillator
  reg wdt_q_r;
  reg [7:0] t8_prev_r; // previous eight-bit count
  reg [7:0] per_prev_r; // previous period timer count
  reg t8_pulse_r; // rising pulse on eight-bit wrap
  reg per_pulse_r; // rising pulse on period reset

  // the pin and the watchdog pulse come from other clocks; the third
  // flop and the agree test keep one metastable sample from counting
  // sync pin and watchdog; first flop only feeds the second
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s_r <= 3'h0;
      pin_q_r <= 1'b0;
      wdt_s_r <= 3'h0;
      wdt_q_r <= 1'b0;
    end
    else
    begin
      pin_s_r <= {pin_s_r[1:0], gate_input_pin_i};
      wdt_s_r <= {wdt_s_r[1:0], watchdog_overflow_i};
      // accept only a level stable in stages two and three
      if (pin_s_r[1] == pin_s_r[2])
        pin_q_r <= pin_s_r[2];
      if (wdt_s_r[1] == wdt_s_r[2])
        wdt_q_r <= wdt_s_r[2];
    end
  end

  // derive wrap pulses from the on-chip timer counts (same clock)
  // these counts share clk_i, so no synchroniser is needed; the
  // one-cycle pulse is enough for the edge logic further down
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      t8_prev_r <= 8'h00;
      per_prev_r <= 8'h00;
      t8_pulse_r <= 1'b0;
      per_pulse_r <= 1'b0;
    end
    else
    begin
      t8_prev_r <= eight_bit_timer_count_i;
      per_prev_r <= period_timer_count_i;
      // ff -> 00 wrap
      t8_pulse_r <= (t8_prev_r == `TGC_T8_MAX) &&
                    (eight_bit_timer_count_i == 8'h00);
      // any nonzero -> 00 is the match reset
      per_pulse_r <= (per_prev_r != 8'h00) &&
                     (period_timer_count_i == 8'h00);
    end
  end

  // ************************************************
  // source select, polarity, toggle, single pulse
  // ************************************************
  reg src_w; // selected raw source
  reg pol_w; // after polarity
  reg src_prev_r; // for incrementing edge of source
  reg tog_r; // toggle flip-flop
  reg mode_w; // after toggle stage
  reg val_w; // gate value after single-pulse stage
  reg val_prev_r;
  reg armed_r; // single pulse: counting enabled after first edge
  wire pol_rise_w;
  wire mode_rise_w;
  wire val_fall_w;

  // changing polarity while toggle mode runs may flip the flop once;
  // software should settle polarity before it enables toggle mode
  always @*
  begin
    case (gate_source_select_i)
      `TGC_SRC_PIN: src_w = pin_q_r;
      `TGC_SRC_T8_OVF: src_w = t8_pulse_r;
      `TGC_SRC_PERIOD: src_w = per_pulse_r;
      `TGC_SRC_WDOG: src_w = wdt_q_r;
      default: src_w = 1'b0;
    endcase
    // polarity 1 counts on high, 0 counts on low
    pol_w = gate_polarity_i ? src_w : ~src_w;
    mode_w = gate_toggle_enable_i ? tog_r : pol_w;
    // single-pulse: only the armed window passes
    if (gate_single_pulse_enable_i)
      val_w = single_pulse_go_done_o & armed_r & mode_w;
    else
      val_w = mode_w;
  end

  assign pol_rise_w = pol_w & ~src_prev_r;
  assign mode_rise_w = gate_toggle_enable_i ? pol_rise_w :
                       pol_rise_w;
  assign val_fall_w = val_prev_r & ~val_w;

  // toggle flop and single-pulse sequencing
  // go is set by software and cleared by the trailing edge or by
  // dropping single-pulse mode; a new go always restarts the arming
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      src_prev_r <= 1'b1; // no false edge from a gate active at reset
      tog_r <= 1'b0;
      armed_r <= 1'b0;
      single_pulse_go_done_o <= 1'b0;
      val_prev_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= pol_w;
      val_prev_r <= val_w;
      // flip on each incrementing source edge, else held clear
      if (!gate_toggle_enable_i)
        tog_r <= 1'b0;
      else if (pol_rise_w)
        tog_r <= ~tog_r;
      if (!gate_single_pulse_enable_i)
      begin
        single_pulse_go_done_o <= 1'b0;
        armed_r <= 1'b0;
      end
      else if (go_set_i)
      begin
        single_pulse_go_done_o <= 1'b1;
        armed_r <= 1'b0;
      end
      else if (single_pulse_go_done_o && !armed_r && mode_rise_w &&
               (gate_toggle_enable_i ? !tog_r : 1'b1))
        armed_r <= 1'b1;
      else if (single_pulse_go_done_o && armed_r && !mode_w)
      begin
        // trailing edge ends the shot; rest ignored
        single_pulse_go_done_o <= 1'b0;
        armed_r <= 1'b0;
      end
    end
  end

  // ************************************************
  // counter, flags, wake and watchdog control
  // ************************************************
  wire run_w;
  wire inc_w;
  wire wrap_w;
  reg ovf_irq_w;

  // on off, always on, or gated
  assign run_w = counter_on_i & (~gate_enable_i | val_w);
  // in sleep only the unsynchronised counter mode advances
  assign inc_w = run_w & count_tick_i &
                 (~sleep_i | external_sync_disable_i);
  assign wrap_w = inc_w && (counter_pair_o == `TGC_CNT_MAX);

  always @*
  begin
    ovf_irq_w = overflow_flag_o & counter_on_i & overflow_irq_enable_i &
                peripheral_irq_enable_i & global_irq_enable_i;
  end

  // count, hold or load; software write wins over increment
  // a load in the cycle of a wrap still sets the overflow flag, so
  // software should stop the counter before it writes the pair
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      counter_pair_o <= `TGC_CNT_RST;
    else if (counter_load_i)
      counter_pair_o <= counter_load_val_i;
    else if (inc_w)
      counter_pair_o <= counter_pair_o + 1'b1;
  end

  // flags: a set in the clear cycle wins
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      gate_level_status_o <= 1'b0;
      gate_event_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      wake_vector_o <= 16'h0000;
      watchdog_osc_on_o <= 1'b0;
      watchdog_reset_allow_o <= 1'b0;
      watchdog_interval_sel_o <= 4'h0;
    end
    else
    begin
      // status follows the gate with gating off too, so software can
      // watch the gate before it turns gating on
      gate_level_status_o <= val_w;
      if (val_fall_w)
        gate_event_flag_o <= 1'b1;
      else if (gate_event_flag_clr_i)
        gate_event_flag_o <= 1'b0;
      if (wrap_w)
        overflow_flag_o <= 1'b1;
      else if (overflow_flag_clr_i)
        overflow_flag_o <= 1'b0;
      irq_o <= ovf_irq_w | (gate_event_flag_o & gate_event_irq_enable_i &
               peripheral_irq_enable_i & global_irq_enable_i);
      // wake on overflow with peripheral enable; vector if global on
      wake_o <= sleep_i & overflow_flag_o & counter_on_i &
                overflow_irq_enable_i & peripheral_irq_enable_i;
      wake_vector_o <= global_irq_enable_i ? `TGC_IRQ_VECTOR : 16'h0000;
      // the watchdog pulse width varies with clears, so software pairs
      // this source with toggle mode and measures whole intervals
      // oscillator on whether or not counter_on is set
      watchdog_osc_on_o <= watchdog_fuse_enable_i | (gate_enable_i &
        (gate_source_select_i == `TGC_SRC_WDOG));
      // only the fuse allows watchdog reset and wake
      watchdog_reset_allow_o <= watchdog_fuse_enable_i;
      watchdog_interval_sel_o <= {prescaler_assignment_i,
                                  prescaler_rate_i};
    end
  end

endmodule // tgc_gate_counter
`default_nettype wire

/* File: bench/tgc_partner.sv */
// far side: gate pin and the other timers that feed the gate block
// assumes one bench clock; updates on its falling edge, like the bench
`timescale 1ns/1ps
`default_nettype none
module tgc_partner (
  input wire logic clk_i,
  input wire logic pin_lvl_i,
  output logic gate_input_pin_o,
  output logic [7:0] eight_bit_timer_count_o,
  output logic [7:0] period_timer_count_o,
  output logic watchdog_overflow_o
);
  logic [5:0] wd_cnt_r = 6'h00; // watchdog interval count
  logic [7:0] t8_r = 8'h00; // eight-bit timer count
  logic [7:0] per_r = 8'h00; // period timer count, limit 1f
  logic wd_r = 1'b0; // watchdog overflow pulse
  // the pin is a plain wire: no race with the bench's own negedge
  assign gate_input_pin_o = pin_lvl_i;
  assign eight_bit_timer_count_o = t8_r;
  assign period_timer_count_o = per_r;
  assign watchdog_overflow_o = wd_r;
  // free-running timers; wd pulse lasts four cycles, longer than sync needs
  always @(negedge clk_i)
  begin
    t8_r <= t8_r + 8'h01;
    per_r <= (per_r == 8'h1f) ? 8'h00 : per_r + 8'h01;
    wd_cnt_r <= wd_cnt_r + 6'h01;
    wd_r <= (wd_cnt_r[5:2] == 4'hf);
  end
endmodule // tgc_partner
`default_nettype wire

/* File: bench/tgc_gate_counter_sva.sv */
// checker: port assertions for the gated counter
// assumes bind to tgc_gate_counter; one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module tgc_gate_counter_sva #(parameter CNT_W = 16) (
  input wire clk_i, rst_n_i, count_tick_i, counter_on_i, gate_enable_i,
  input wire [1:0] gate_source_select_i,
  input wire gate_single_pulse_enable_i, counter_load_i, sleep_i,
  input wire watchdog_fuse_enable_i, prescaler_assignment_i,
  input wire [2:0] prescaler_rate_i,
  input wire overflow_irq_enable_i, peripheral_irq_enable_i,
  input wire global_irq_enable_i, single_pulse_go_done_o, irq_o,
  input wire gate_level_status_o, gate_event_flag_o, overflow_flag_o,
  input wire watchdog_osc_on_o, watchdog_reset_allow_o,
  input wire [3:0] watchdog_interval_sel_o,
  input wire [CNT_W-1:0] counter_pair_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ovf_on_wrap: assert property (
    $past(counter_pair_o) == 16'hffff && counter_pair_o == 16'h0000 &&
    !$past(counter_load_i) |-> overflow_flag_o) else $error("no ovf flag");
  chk_off_holds: assert property (
    !counter_on_i && !counter_load_i |=> $stable(counter_pair_o))
    else $error("counter moved while off");
  chk_free_run: assert property (
    counter_on_i && !gate_enable_i && count_tick_i && !counter_load_i &&
    !sleep_i |=> counter_pair_o == $past(counter_pair_o) + 16'h0001)
    else $error("ungated count missed");
  chk_irq_cause: assert property (
    $rose(irq_o) |-> gate_event_flag_o || $past(gate_event_flag_o) ||
    $past(overflow_flag_o && overflow_irq_enable_i && counter_on_i &&
    peripheral_irq_enable_i && global_irq_enable_i)) else $error("bad irq");
  chk_spm_clears_go: assert property (
    !gate_single_pulse_enable_i |=> !single_pulse_go_done_o)
    else $error("go stayed set");
  chk_wdog_osc_on: assert property (
    gate_enable_i && gate_source_select_i == 2'h3 |=> watchdog_osc_on_o)
    else $error("wdog osc off");
  chk_no_wdog_reset: assert property (
    !watchdog_fuse_enable_i |=> !watchdog_reset_allow_o)
    else $error("wdog reset allowed");
  chk_interval_sel: assert property (
    1'b1 |=> watchdog_interval_sel_o ==
    $past({prescaler_assignment_i, prescaler_rate_i})) else $error("ivl");
  chk_flag_on_fall: assert property (
    $fell(gate_level_status_o) |-> ##[0:2] gate_event_flag_o)
    else $error("no gate event flag");
endmodule // tgc_gate_counter_sva
bind tgc_gate_counter tgc_gate_counter_sva #(.CNT_W(CNT_W)) u_sva (.*);
`default_nettype wire

/* File: bench/tgc_gate_counter_test.sv */
// testbench: gated 16-bit counter against the far-side model
// assumes 40 MHz clock; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module tgc_gate_counter_test;
  logic clk_i, rst_n_i, count_tick_i, counter_on_i, gate_enable_i, pin;
  logic gate_polarity_i, gate_toggle_enable_i, gate_single_pulse_enable_i;
  logic go_set_i, watchdog_fuse_enable_i, prescaler_assignment_i, sleep_i;
  logic counter_load_i, gate_event_flag_clr_i, overflow_flag_clr_i;
  logic gate_event_irq_enable_i, overflow_irq_enable_i;
  logic peripheral_irq_enable_i, global_irq_enable_i, external_sync_disable_i;
  logic [1:0] gate_source_select_i;
  logic [2:0] prescaler_rate_i;
  logic [15:0] counter_load_val_i;
  wire logic gate_input_pin_i, watchdog_overflow_i;
  wire logic [7:0] eight_bit_timer_count_i, period_timer_count_i;
  wire logic [15:0] counter_pair_o, wake_vector_o;
  wire logic [3:0] watchdog_interval_sel_o;
  wire logic single_pulse_go_done_o, gate_level_status_o, gate_event_flag_o;
  wire logic overflow_flag_o, irq_o, wake_o, watchdog_osc_on_o;
  wire logic watchdog_reset_allow_o;
  int n_fail = 0, comparisons = 0, cycles = 0;
  tgc_gate_counter #(.CNT_W(16)) dut (.*);
  tgc_partner u_far (.clk_i, .pin_lvl_i(pin),
    .gate_input_pin_o(gate_input_pin_i),
    .eight_bit_timer_count_o(eight_bit_timer_count_i),
    .period_timer_count_o(period_timer_count_i),
    .watchdog_overflow_o(watchdog_overflow_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic load(input logic [15:0] v, input int n);
    counter_load_val_i = v;
    counter_load_i = 1;
    cyc(n);
    counter_load_i = 0;
  endtask
  task automatic clr_flags;
    {gate_event_flag_clr_i, overflow_flag_clr_i} = 2'h3;
    cyc(1);
    {gate_event_flag_clr_i, overflow_flag_clr_i} = 2'h0;
    cyc(1);
  endtask
  task automatic go_pulse;
    go_set_i = 1;
    cyc(1);
    go_set_i = 0;
  endtask
  task automatic gate_pulse;
    pin = 1;
    cyc(10);
    pin = 0;
    cyc(8);
  endtask
  task automatic t_free;
    counter_on_i = 1;
    pin = 1; // would hold the count if gating were on
    {peripheral_irq_enable_i, overflow_irq_enable_i} = 2'h3;
    load(16'hfffd, 1);
    cyc(4);
    chk(counter_pair_o, 16'h0001);
    chk(overflow_flag_o, 1);
    chk(irq_o, 0);
    global_irq_enable_i = 1;
    cyc(2);
    chk(irq_o, 1);
    counter_on_i = 0;
    cyc(3);
    chk(counter_pair_o, 16'h0003);
    clr_flags;
    chk(overflow_flag_o, 0);
  endtask
  task automatic t_pol;
    {gate_enable_i, counter_on_i} = 2'h3;
    for (int k = 0; k < 4; k++)
    begin
      {gate_polarity_i, pin} = k[1:0];
      load(16'h0000, 8);
      cyc(8);
      chk(counter_pair_o, (k == 0 || k == 3) ? 16'h8 : 16'h0);
      chk(gate_level_status_o, k == 0 || k == 3);
    end
    gate_enable_i = 0; // flag and status still work ungated
    clr_flags;
    pin = 0;
    cyc(8);
    chk(gate_event_flag_o, 1);
    chk(gate_level_status_o, 0);
    gate_event_irq_enable_i = 1;
    cyc(2);
    chk(irq_o, 1);
    gate_event_irq_enable_i = 0;
    clr_flags;
    chk(irq_o, 0);
  endtask
  task automatic t_src;
    gate_enable_i = 1;
    for (int s = 1; s < 4; s++)
    begin
      gate_source_select_i = s[1:0];
      prescaler_rate_i = s[2:0]; // interval bits must follow the inputs
      gate_toggle_enable_i = 0; // start each window with the flop clear
      load(16'h0000, 4);
      gate_toggle_enable_i = 1;
      cyc(600);
      chk(counter_pair_o > 0 && counter_pair_o < 600, 1);
      chk(watchdog_osc_on_o, s == 3);
      chk(watchdog_interval_sel_o, {1'b1, s[2:0]});
      chk(watchdog_reset_allow_o, 0);
    end
  endtask
  task automatic t_single;
    logic [15:0] v;
    gate_toggle_enable_i = 0;
    gate_source_select_i = 2'h0;
    gate_single_pulse_enable_i = 1;
    load(16'h0000, 8);
    go_pulse;
    cyc(4);
    chk(single_pulse_go_done_o, 1);
    chk(counter_pair_o, 0);
    gate_pulse;
    v = counter_pair_o;
    chk(single_pulse_go_done_o, 0);
    chk(v > 0 && v < 11, 1);
    gate_pulse;
    chk(counter_pair_o, v);
    go_pulse;
    gate_single_pulse_enable_i = 0;
    cyc(2);
    chk(single_pulse_go_done_o, 0);
    // toggle and single pulse together: one full 18-cycle gate period
    gate_toggle_enable_i = 1;
    gate_single_pulse_enable_i = 1;
    load(16'h0000, 2);
    go_pulse;
    gate_pulse;
    gate_pulse;
    chk(single_pulse_go_done_o, 0);
    chk(counter_pair_o > 16 && counter_pair_o < 20, 1);
    {gate_toggle_enable_i, gate_single_pulse_enable_i} = 2'h0;
  endtask
  task automatic t_sleep;
    {gate_enable_i, sleep_i, external_sync_disable_i} = 3'h2;
    clr_flags;
    load(16'hfffe, 1);
    cyc(4);
    chk(counter_pair_o, 16'hfffe);
    chk(wake_o, 0);
    external_sync_disable_i = 1;
    for (int i = 0; i < 10 && wake_o !== 1'b1; i++)
      cyc(1);
    chk(wake_o, 1);
    chk(wake_vector_o, 16'h0004);
  endtask
  task automatic t_reset;
    rst_n_i = 0; // reset again in mid-run, counter still running
    cyc(2);
    chk(counter_pair_o, 16'h0000);
    chk({wake_o, overflow_flag_o, gate_event_flag_o, irq_o}, 0);
    chk(wake_vector_o, 16'h0000);
    rst_n_i = 1;
    cyc(2);
    chk(overflow_flag_o, 0);
    chk(wake_vector_o, 16'h0004);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial
  begin
    {rst_n_i, counter_on_i, gate_enable_i, pin, gate_polarity_i} = 5'h00;
    {gate_toggle_enable_i, gate_single_pulse_enable_i, go_set_i} = 3'h0;
    {watchdog_fuse_enable_i, sleep_i, counter_load_i} = 3'h0;
    {gate_event_flag_clr_i, overflow_flag_clr_i} = 2'h0;
    {gate_event_irq_enable_i, overflow_irq_enable_i} = 2'h0;
    {peripheral_irq_enable_i, global_irq_enable_i} = 2'h0;
    {external_sync_disable_i, gate_source_select_i} = 3'h0;
    {prescaler_assignment_i, prescaler_rate_i} = 4'ha;
    counter_load_val_i = 16'h0000;
    count_tick_i = 1;
    cyc(2);
    rst_n_i = 1;
    t_free;
    t_pol;
    t_src;
    t_single;
    t_sleep;
    t_reset;
    tally_and_finish;
  end
endmodule // tgc_gate_counter_test
`default_nettype wire
